// ===== ctmi_map.svh
/*
 Register indices, field positions, reset values and timing figures
 of the clock timer. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef CTMI_MAP_SVH
`define CTMI_MAP_SVH

// ==========================================================
// Bus
`define CTMI_ADDR_W 18
`define CTMI_RESP_OKAY 2'h0
`define CTMI_RESP_SLVERR 2'h2

// ==========================================================
// Register indices (byte address is four times the index)
`define CTMI_IDX_CTRL 16'hff78
`define CTMI_IDX_LOW 16'hff79
`define CTMI_IDX_HIGH 16'hff7a
`define CTMI_IDX_EN 16'hffe6
`define CTMI_IDX_FLAG 16'hfff6
`define CTMI_IDX_CLR 16'hfff0

// ==========================================================
// Fields and reset values
`define CTMI_CTRL_RUN 0
`define CTMI_CTRL_CLR 1
`define CTMI_TAP_32HZ 2
`define CTMI_TAP_8HZ 4
`define CTMI_TAP_2HZ 6
`define CTMI_TAP_1HZ 7
`define CTMI_CNT_RST 8'h00
`define CTMI_NIB_RST 4'h0
`define CTMI_RUN_RST 1'h0

// ==========================================================
// Timing
`define CTMI_CLK_HZ 20000000
`define CTMI_CLK_NS 50
`define CTMI_TICK_HZ 256
`define CTMI_HOLD_MIN_NS 480000

`endif

// ===== ctmi_pkg.sv
/*
 Types shared by the clock timer design.
 Assumes ctmi_map.svh holds the numeric constants.
*/
package ctmi_pkg;

	// ==========================================================
	// Register selection
	typedef enum logic [2:0] {
		CTMI_REG_NONE = 3'h0,
		CTMI_REG_CTRL = 3'h1,
		CTMI_REG_LOW = 3'h2,
		CTMI_REG_HIGH = 3'h3,
		CTMI_REG_EN = 3'h4,
		CTMI_REG_FLAG = 3'h5,
		CTMI_REG_CLR = 3'h6
	} ctmi_reg_e;

	// ==========================================================
	// High nibble freeze state
	typedef enum logic [0:0] {
		CTMI_FRZ_OFF = 1'h0,
		CTMI_FRZ_ON = 1'h1
	} ctmi_frz_e;

endpackage : ctmi_pkg

// ===== ctmi_top.sv
/*
 Clock timer with four tap interrupts behind an AXI4-Lite slave.
 Assumes a 20 MHz aclk, synchronous active-low reset, and a master
 that keeps at most one write and one read under way.
*/
// The implementer's own choice: the AXI4-Lite interface to the registers.
// Notes on behaviour
// - Count nibbles are read-only; writes ignored
// - Count bits run 128 Hz up to 1 Hz
// - Low read freezes high nibble, bounded time
// - Reset clears all count bits
// - Clear bit zeroes count; run bit takes bit 0 of the same write
// - Clear bit write-only, zero write no effect
// - Run bit starts or stops counting, readable
// - Stopped timer holds count, resumes from it
// - Reset leaves timer stopped
// - Four mask bits enable tap interrupts
// - Reset masks all tap interrupts
// - Four flag bits show tap events
// - Flag set on tap falling edge, unmasked
// - Writing one clears a flag
// - Reset clears all flags
`timescale 1ns/1ns
`include "ctmi_map.svh"

module ctmi_top #(
	parameter int TICK_CYCLES = `CTMI_CLK_HZ / `CTMI_TICK_HZ,
	parameter int HOLD_CYCLES = (`CTMI_HOLD_MIN_NS + `CTMI_CLK_NS - 1) / `CTMI_CLK_NS
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [`CTMI_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// Write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address channel
	input wire logic [`CTMI_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// Read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Interrupt
	output logic irq
);
	import ctmi_pkg::*;

	// ==========================================================
	// Constants
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);

	// ==========================================================
	// Functions
	function automatic ctmi_reg_e reg_sel(input logic [`CTMI_ADDR_W-1:0] a);
		logic [15:0] idx;
		ctmi_reg_e r;
		idx = a[`CTMI_ADDR_W-1:2];
		r = CTMI_REG_NONE;
		if (a[1:0] == 2'h0)
		begin
			case (idx)
				`CTMI_IDX_CTRL: r = CTMI_REG_CTRL;
				`CTMI_IDX_LOW: r = CTMI_REG_LOW;
				`CTMI_IDX_HIGH: r = CTMI_REG_HIGH;
				`CTMI_IDX_EN: r = CTMI_REG_EN;
				`CTMI_IDX_FLAG: r = CTMI_REG_FLAG;
				`CTMI_IDX_CLR: r = CTMI_REG_CLR;
				default: r = CTMI_REG_NONE;
			endcase
		end
		return r;
	endfunction : reg_sel

	function automatic int tap_of(input int i);
		int t;
		case (i)
			0: t = `CTMI_TAP_32HZ;
			1: t = `CTMI_TAP_8HZ;
			2: t = `CTMI_TAP_2HZ;
			default: t = `CTMI_TAP_1HZ;
		endcase
		return t;
	endfunction : tap_of

	// ==========================================================
	// State
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [`CTMI_ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic run_q;
	logic [7:0] cnt_q;
	logic [PRE_W-1:0] pre_q;
	ctmi_frz_e frz_q;
	logic [3:0] frz_val_q;
	logic [HOLD_W-1:0] hold_q;
	logic [3:0] en_q;
	logic [3:0] flag_q;

	// ==========================================================
	// Bus decode
	wire aw_go = awvalid & awready_q;
	wire w_go = wvalid & wready_q;
	wire ar_go = arvalid & arready_q;
	wire b_done = bvalid_q & bready;
	wire r_done = rvalid_q & rready;
	wire wr_go = !awready_q & !wready_q & !bvalid_q;
	wire ctmi_reg_e wr_sel = reg_sel(awaddr_q);
	wire ctmi_reg_e rd_sel = reg_sel(araddr);
	wire wr_lane = wr_go & wstrb_q[0];
	wire wr_ctrl = wr_lane && wr_sel == CTMI_REG_CTRL;
	wire wr_en = wr_lane && wr_sel == CTMI_REG_EN;
	wire wr_flag = wr_lane && (wr_sel == CTMI_REG_FLAG || wr_sel == CTMI_REG_CLR);
	wire wr_cnt = wr_go && (wr_sel == CTMI_REG_LOW || wr_sel == CTMI_REG_HIGH);
	wire [1:0] bresp_d = (wr_sel == CTMI_REG_NONE) ? `CTMI_RESP_SLVERR : `CTMI_RESP_OKAY;
	wire [1:0] rresp_d = (rd_sel == CTMI_REG_NONE) ? `CTMI_RESP_SLVERR : `CTMI_RESP_OKAY;

	// ==========================================================
	// Timer core
	wire clr_go = wr_ctrl & wdata_q[`CTMI_CTRL_CLR];
	wire tick = run_q && pre_q == PRE_LAST;
	wire [7:0] cnt_inc = cnt_q + 8'h01;
	wire run_d = wr_ctrl ? wdata_q[`CTMI_CTRL_RUN] : run_q;
	wire [PRE_W-1:0] pre_inc = pre_q + PRE_W'(1);
	wire [PRE_W-1:0] pre_d = (clr_go || tick) ? '0 : (run_q ? pre_inc : pre_q);
	// Counting is the only writer besides clear; bus writes to count never land
	wire [7:0] cnt_d = clr_go ? `CTMI_CNT_RST : (tick ? cnt_inc : cnt_q);

	// ==========================================================
	// High nibble freeze
	wire rd_low = ar_go && rd_sel == CTMI_REG_LOW;
	wire rd_high = ar_go && rd_sel == CTMI_REG_HIGH;
	wire frz_end = frz_q == CTMI_FRZ_ON && (rd_high || hold_q == '0);
	wire [HOLD_W-1:0] hold_dec = hold_q - HOLD_W'(1);
	wire [HOLD_W-1:0] hold_d = rd_low ? HOLD_LAST : (frz_end ? '0 : hold_dec);
	wire [3:0] frz_val_d = rd_low ? cnt_q[7:4] : frz_val_q;
	wire [3:0] high_view = (frz_q == CTMI_FRZ_ON) ? frz_val_q : cnt_q[7:4];
	ctmi_frz_e frz_d;

	always_comb
	begin
		frz_d = frz_q;
		case (frz_q)
			CTMI_FRZ_OFF: if (rd_low) frz_d = CTMI_FRZ_ON;
			CTMI_FRZ_ON: if (!rd_low && frz_end) frz_d = CTMI_FRZ_OFF;
			default: frz_d = CTMI_FRZ_OFF;
		endcase
	end

	// ==========================================================
	// Flags, masks and interrupt
	wire [3:0] flag_clr = wr_flag ? wdata_q[3:0] : 4'h0;
	wire [3:0] en_d = wr_en ? wdata_q[3:0] : en_q;
	wire [3:0] fall;
	wire [3:0] flag_d;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_flag
			// Set wins over a clear landing in the same cycle
			assign fall[gi] = tick & cnt_q[tap_of(gi)] & ~cnt_inc[tap_of(gi)];
			assign flag_d[gi] = fall[gi] | (flag_q[gi] & ~flag_clr[gi]);
		end
	endgenerate

	wire irq_d = |(flag_d & en_d);

	// ==========================================================
	// Read data
	wire [3:0] rd_nib =
		(rd_sel == CTMI_REG_CTRL) ? {3'h0, run_q} :
		(rd_sel == CTMI_REG_LOW) ? cnt_q[3:0] :
		(rd_sel == CTMI_REG_HIGH) ? high_view :
		(rd_sel == CTMI_REG_EN) ? en_q :
		(rd_sel == CTMI_REG_FLAG) ? flag_q : `CTMI_NIB_RST;
	wire [31:0] rdata_d = {28'h0000000, rd_nib};

	// ==========================================================
	// Bus registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'h1;
			wready_q <= 1'h1;
			bvalid_q <= 1'h0;
			bresp_q <= `CTMI_RESP_OKAY;
		end
		else
		begin
			if (aw_go) awready_q <= 1'h0;
			if (w_go) wready_q <= 1'h0;
			if (wr_go) bvalid_q <= 1'h1;
			if (wr_go) bresp_q <= bresp_d;
			if (b_done) bvalid_q <= 1'h0;
			if (b_done) awready_q <= 1'h1;
			if (b_done) wready_q <= 1'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (aw_go) awaddr_q <= awaddr;
		if (w_go) wdata_q <= wdata;
		if (w_go) wstrb_q <= wstrb;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'h1;
			rvalid_q <= 1'h0;
			rresp_q <= `CTMI_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end
		else if (ar_go)
		begin
			arready_q <= 1'h0;
			rvalid_q <= 1'h1;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
		else if (r_done)
		begin
			arready_q <= 1'h1;
			rvalid_q <= 1'h0;
		end
	end

	// ==========================================================
	// Timer registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			run_q <= `CTMI_RUN_RST;
			cnt_q <= `CTMI_CNT_RST;
			pre_q <= '0;
			en_q <= `CTMI_NIB_RST;
			flag_q <= `CTMI_NIB_RST;
			irq_q <= 1'h0;
			frz_q <= CTMI_FRZ_OFF;
			frz_val_q <= `CTMI_NIB_RST;
			hold_q <= '0;
		end
		else
		begin
			run_q <= run_d;
			cnt_q <= cnt_d;
			pre_q <= pre_d;
			en_q <= en_d;
			flag_q <= flag_d;
			irq_q <= irq_d;
			frz_q <= frz_d;
			frz_val_q <= frz_val_d;
			hold_q <= hold_d;
		end
	end

	// ==========================================================
	// Outputs
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign irq = irq_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_count_readonly: assert property (
		wr_cnt && !tick |=> cnt_q == $past(cnt_q))
		else $error("count changed by a bus write");

	chk_count_step: assert property (
		tick && !clr_go |=> cnt_q == $past(cnt_inc))
		else $error("count did not step by one");

	chk_freeze_value: assert property (
		rd_low ##1 (!rd_low && !rd_high)[*3] |-> frz_q == CTMI_FRZ_ON
			&& frz_val_q == $past(cnt_q[7:4], 3))
		else $error("high nibble not frozen after low read");

	chk_freeze_bound: assert property (
		frz_q == CTMI_FRZ_ON && hold_q == '0 && !rd_low |=> frz_q == CTMI_FRZ_OFF)
		else $error("freeze outlived its hold time");

	chk_reset_values: assert property (
		disable iff (1'b0) !aresetn |=> cnt_q == `CTMI_CNT_RST && !run_q
			&& en_q == `CTMI_NIB_RST && flag_q == `CTMI_NIB_RST)
		else $error("reset values wrong");

	chk_clear_zero: assert property (
		clr_go |=> cnt_q == `CTMI_CNT_RST ##1 (cnt_q == `CTMI_CNT_RST || run_q))
		else $error("clear did not zero the count");

	chk_ctrl_read: assert property (
		ar_go && rd_sel == CTMI_REG_CTRL |=> rdata_q[`CTMI_CTRL_CLR] == 1'h0
			&& rdata_q[`CTMI_CTRL_RUN] == $past(run_q))
		else $error("control read wrong");

	chk_run_write: assert property (
		wr_ctrl |=> run_q == $past(wdata_q[`CTMI_CTRL_RUN]))
		else $error("run bit not stored");

	chk_stop_hold: assert property (
		!run_q && !clr_go |=> cnt_q == $past(cnt_q))
		else $error("stopped timer moved");

	chk_mask_read: assert property (
		ar_go && (rd_sel == CTMI_REG_EN || rd_sel == CTMI_REG_FLAG) |=>
			rdata_q[3:0] == ($past(rd_sel) == CTMI_REG_EN ? $past(en_q) : $past(flag_q)))
		else $error("mask or flag read wrong");

	chk_flag_set: assert property (
		tick && cnt_q[`CTMI_TAP_1HZ] && !cnt_inc[`CTMI_TAP_1HZ] |=> flag_q[3])
		else $error("1 Hz flag not set on falling edge");

	chk_flag_clear: assert property (
		wr_flag && wdata_q[0] && !fall[0] |=> !flag_q[0])
		else $error("32 Hz flag not cleared");

	chk_irq_level: assert property (
		irq_q == |(flag_q & en_q))
		else $error("interrupt does not follow enabled flags");

	chk_freeze_start: assert property (
		rd_low |=> frz_q == CTMI_FRZ_ON && frz_val_q == $past(cnt_q[7:4]))
		else $error("low read did not freeze the high nibble");

	chk_flag_unmasked: assert property (
		(|fall) |=> (flag_q & $past(fall)) == $past(fall))
		else $error("tap edge did not set its flag");

	chk_flag_sticky: assert property (
		!(|fall) && !(|flag_clr) |=> flag_q == $past(flag_q))
		else $error("flag changed without event or clear");

	cov_clear_running: cover property (run_q && clr_go ##[1:8] tick);
	cov_stop_resume: cover property (!run_q ##1 run_q);
	cov_low_then_high: cover property (rd_low ##[1:20] rd_high);
	cov_freeze_timeout: cover property (frz_q == CTMI_FRZ_ON && hold_q == '0);
	cov_irq_raise: cover property (!irq_q ##1 irq_q);

endmodule : ctmi_top

// ===== ctmi_top_tb.sv
/*
 Self-checking bench for the clock timer behind its AXI4-Lite slave.
 Assumes ctmi_top and ctmi_map.svh; the tick and hold counts are shortened.
*/
`timescale 1ns/1ns
`include "ctmi_map.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end

module ctmi_top_tb;
	import ctmi_pkg::*;
	localparam int TICK = 4;
	localparam int HOLD = 8;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [17:0] awaddr = '0;
	logic [17:0] araddr = '0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [31:0] wdata = '0;
	logic awready;
	logic wready;
	logic arready;
	logic bvalid;
	logic rvalid;
	logic irq;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic [31:0] rd_d;
	logic [7:0] c;
	logic [7:0] c1;
	int comparisons = 0;
	int miscompares = 0;
	int cycles = 0;
	int m_en;
	int m_flags;
	logic [15:0] regs [6] = '{`CTMI_IDX_CTRL, `CTMI_IDX_LOW, `CTMI_IDX_HIGH,
		`CTMI_IDX_EN, `CTMI_IDX_FLAG, `CTMI_IDX_CLR};

	ctmi_top #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) u_ctmi_top (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.irq(irq)
	);

	always #25 aclk = ~aclk;

	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic [1:0] er);
		logic a;
		logic w;
		a = 1'h0;
		w = 1'h0;
		awaddr <= {i, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(a && w))
		begin
			@(posedge aclk);
			if (!a && awready)
			begin
				a = 1'h1;
				awvalid <= 1'h0;
			end
			if (!w && wready)
			begin
				w = 1'h1;
				wvalid <= 1'h0;
			end
		end
		// Raised here so a call right after another never drives it twice in one step
		bready <= 1'h1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'h0;
		`CHK("bresp", er, bresp)
	endtask : wr

	task automatic rd(input logic [15:0] i, input logic [1:0] er);
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'h0;
		rd_d = rdata;
		`CHK("rresp", er, rresp)
	endtask : rd

	task automatic cnt();
		rd(`CTMI_IDX_LOW, 2'h0);
		c[3:0] = rd_d[3:0];
		rd(`CTMI_IDX_HIGH, 2'h0);
		c[7:4] = rd_d[3:0];
	endtask : cnt

	// Flags expected after counting up from zero to v
	function automatic int exp_flags(input int v, input bit wrapped);
		if (wrapped)
			return 15;
		return int'(v >= 8) | (int'(v >= 32) << 1) | (int'(v >= 128) << 2);
	endfunction : exp_flags

	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			miscompares++;
			complete_run();
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(54));
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		foreach (regs[k])
		begin
			rd(regs[k], 2'h0);
			`CHK("reset value", 32'h0, rd_d)
		end
		`CHK("irq at reset", 1'h0, irq)
		rd(16'h0001, 2'h2);
		`CHK("unmapped read", 32'h0, rd_d)
		wr(16'h0001, 32'hf, 2'h2);
		$display("test reset done");
		wr(`CTMI_IDX_LOW, 32'hf, 2'h0);
		wr(`CTMI_IDX_HIGH, 32'hf, 2'h0);
		cnt();
		`CHK("count after write", 8'h00, c)
		wr(`CTMI_IDX_CTRL, 32'h2, 2'h0);
		rd(`CTMI_IDX_CTRL, 2'h0);
		`CHK("clear bit read", 32'h0, rd_d)
		wr(`CTMI_IDX_CTRL, 32'h1, 2'h0);
		rd(`CTMI_IDX_CTRL, 2'h0);
		`CHK("run bit read", 32'h1, rd_d)
		repeat (600) @(posedge aclk);
		wr(`CTMI_IDX_CTRL, 32'h0, 2'h0);
		cnt();
		c1 = c;
		`CHK("count rate", 1'h1, c >= 8'd145 && c <= 8'd153)
		rd(`CTMI_IDX_FLAG, 2'h0);
		`CHK("masked flags", exp_flags(c, 0), rd_d)
		repeat (40) @(posedge aclk);
		cnt();
		`CHK("held count", c1, c)
		$display("test run and stop done");
		rd(`CTMI_IDX_LOW, 2'h0);
		wr(`CTMI_IDX_CTRL, 32'h2, 2'h0);
		rd(`CTMI_IDX_HIGH, 2'h0);
		`CHK("frozen high", {28'h0, c1[7:4]}, rd_d)
		rd(`CTMI_IDX_HIGH, 2'h0);
		`CHK("released high", 32'h0, rd_d)
		repeat (20) @(posedge aclk);
		cnt();
		`CHK("cleared stopped", 8'h00, c)
		$display("test freeze done");
		wr(`CTMI_IDX_CTRL, 32'h1, 2'h0);
		repeat (1200) @(posedge aclk);
		wr(`CTMI_IDX_CTRL, 32'h0, 2'h0);
		rd(`CTMI_IDX_FLAG, 2'h0);
		m_flags = exp_flags(0, 1);
		`CHK("wrapped flags", m_flags, rd_d)
		rd(`CTMI_IDX_LOW, 2'h0);
		wr(`CTMI_IDX_CTRL, 32'h2, 2'h0);
		repeat (HOLD + 4) @(posedge aclk);
		rd(`CTMI_IDX_HIGH, 2'h0);
		`CHK("freeze expiry", 32'h0, rd_d)
		wr(`CTMI_IDX_CTRL, 32'h1, 2'h0);
		repeat (40) @(posedge aclk);
		// Clear while running: counting restarts from zero at once
		wr(`CTMI_IDX_CTRL, 32'h3, 2'h0);
		rd(`CTMI_IDX_CTRL, 2'h0);
		`CHK("run after clear", 32'h1, rd_d)
		repeat (40) @(posedge aclk);
		wr(`CTMI_IDX_CTRL, 32'h0, 2'h0);
		cnt();
		`CHK("restart from zero", 1'h1, c >= 8'd10 && c <= 8'd12)
		$display("test wrap and clear done");
		wr(`CTMI_IDX_FLAG, 32'h5, 2'h0);
		wr(`CTMI_IDX_FLAG, 32'h0, 2'h0);
		m_flags = m_flags & ~5;
		rd(`CTMI_IDX_FLAG, 2'h0);
		`CHK("flags after clear", m_flags, rd_d)
		wr(`CTMI_IDX_CLR, 32'h2, 2'h0);
		m_flags = m_flags & ~2;
		rd(`CTMI_IDX_FLAG, 2'h0);
		`CHK("flags after alias", m_flags, rd_d)
		`CHK("irq masked", 1'h0, irq)
		repeat (8)
		begin
			m_en = $urandom & 15;
			wr(`CTMI_IDX_EN, 32'(m_en), 2'h0);
			rd(`CTMI_IDX_EN, 2'h0);
			`CHK("enable read", m_en, rd_d)
			`CHK("irq level", (m_flags & m_en) != 0, irq)
		end
		wr(`CTMI_IDX_EN, 32'h8, 2'h0);
		`CHK("irq raised", 1'h1, irq)
		// Handler clears the serviced flag before leaving
		wr(`CTMI_IDX_FLAG, 32'h8, 2'h0);
		`CHK("irq cleared", 1'h0, irq)
		$display("test interrupts done");
		wr(`CTMI_IDX_CTRL, 32'h1, 2'h0);
		wr(`CTMI_IDX_EN, 32'hf, 2'h0);
		repeat (100) @(posedge aclk);
		`CHK("irq before reset", 1'h1, irq)
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		foreach (regs[k])
		begin
			rd(regs[k], 2'h0);
			`CHK("value after reset", 32'h0, rd_d)
		end
		`CHK("irq after reset", 1'h0, irq)
		$display("test reset in run done");
		complete_run();
	end

endmodule : ctmi_top_tb
